// *** hw/mim_pkg.sv ***
// Package: constants and types of the memory region hash monitor
// Functional notes
// - Digest is 160, 224 or 256 bits
// - Enabled monitor fetches descriptors as circular list
// - At most four regions per list
// - Each descriptor holds four words
// - Hashing starts right after descriptor load
// - Move programmed block count plus one blocks into hash engine
// - Then write digest back or compare it
// - Mismatch raises interrupt only when its mask bit is set
// - Walk descriptors until end marker or disable; wrap returns to the first descriptor
package mim_pkg;
    // Register port map
    localparam int ADDR_W = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_BASE = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_MASK = 8'h0C;
    localparam logic [7:0] REG_STATE = 8'h10;
    localparam int CTRL_EN_BIT = 0;
    localparam int EV_W = 2;
    localparam int EV_MISMATCH = 0;
    localparam int EV_END = 1;
    // Descriptor layout: word index and config fields
    localparam int DW_START = 0;
    localparam int DW_CFG = 1;
    localparam int DW_CTRL = 2;
    localparam int DW_DIG = 3;
    localparam int CFG_WRAP_BIT = 0;
    localparam int CFG_EOM_BIT = 1;
    localparam int CFG_CMP_BIT = 2;
    localparam int CFG_ALGO_LSB = 4;
    localparam int CNT_W = 16;
    localparam logic [3:0] DESC_LAST = 4'h3;
    localparam logic [3:0] BLK_LAST = 4'hF;
    localparam logic [1:0] REGION_LAST = 2'h3;
    localparam logic [31:0] WORD_BYTES = 32'h4;
    localparam logic [31:0] BLK_BYTES = 32'h40;
    localparam logic [2:0] WORD_TOP = 3'h7;
    // Hash algorithms
    localparam logic [1:0] ALGO_SHA1 = 2'h0;
    localparam logic [1:0] ALGO_SHA256 = 2'h1;
    localparam logic [1:0] ALGO_SHA224 = 2'h2;
    localparam logic [3:0] DIGW_SHA1 = 4'h5;
    localparam logic [3:0] DIGW_SHA224 = 4'h7;
    localparam logic [3:0] DIGW_SHA256 = 4'h8;
    localparam logic [6:0] ROUNDS_SHA1 = 7'h50;
    localparam logic [6:0] ROUNDS_SHA2 = 7'h40;
    localparam logic [6:0] SHA1_P1 = 7'h14;
    localparam logic [6:0] SHA1_P2 = 7'h28;
    localparam logic [6:0] SHA1_P3 = 7'h3C;
    localparam logic [7:0][31:0] IV_SHA1 = {
        32'h67452301, 32'hEFCDAB89, 32'h98BADCFE, 32'h10325476,
        32'hC3D2E1F0, 32'h00000000, 32'h00000000, 32'h00000000};
    localparam logic [7:0][31:0] IV_SHA256 = {
        32'h6A09E667, 32'hBB67AE85, 32'h3C6EF372, 32'hA54FF53A,
        32'h510E527F, 32'h9B05688C, 32'h1F83D9AB, 32'h5BE0CD19};
    localparam logic [7:0][31:0] IV_SHA224 = {
        32'hC1059ED8, 32'h367CD507, 32'h3070DD17, 32'hF70E5939,
        32'hFFC00B31, 32'h68581511, 32'h64F98FA7, 32'hBEFA4FA4};
    localparam logic [0:3][31:0] K_SHA1 = {
        32'h5A827999, 32'h6ED9EBA1, 32'h8F1BBCDC, 32'hCA62C1D6};
    localparam logic [0:63][31:0] K_SHA2 = {
        32'h428A2F98, 32'h71374491, 32'hB5C0FBCF, 32'hE9B5DBA5,
        32'h3956C25B, 32'h59F111F1, 32'h923F82A4, 32'hAB1C5ED5,
        32'hD807AA98, 32'h12835B01, 32'h243185BE, 32'h550C7DC3,
        32'h72BE5D74, 32'h80DEB1FE, 32'h9BDC06A7, 32'hC19BF174,
        32'hE49B69C1, 32'hEFBE4786, 32'h0FC19DC6, 32'h240CA1CC,
        32'h2DE92C6F, 32'h4A7484AA, 32'h5CB0A9DC, 32'h76F988DA,
        32'h983E5152, 32'hA831C66D, 32'hB00327C8, 32'hBF597FC7,
        32'hC6E00BF3, 32'hD5A79147, 32'h06CA6351, 32'h14292967,
        32'h27B70A85, 32'h2E1B2138, 32'h4D2C6DFC, 32'h53380D13,
        32'h650A7354, 32'h766A0ABB, 32'h81C2C92E, 32'h92722C85,
        32'hA2BFE8A1, 32'hA81A664B, 32'hC24B8B70, 32'hC76C51A3,
        32'hD192E819, 32'hD6990624, 32'hF40E3585, 32'h106AA070,
        32'h19A4C116, 32'h1E376C08, 32'h2748774C, 32'h34B0BCB5,
        32'h391C0CB3, 32'h4ED8AA4A, 32'h5B9CCA4F, 32'h682E6FF3,
        32'h748F82EE, 32'h78A5636F, 32'h84C87814, 32'h8CC70208,
        32'h90BEFFFA, 32'hA4506CEB, 32'hBEF9A3F7, 32'hC67178F2};
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_DESC = 3'b001,
        S_BLK = 3'b010,
        S_HASH = 3'b011,
        S_DIG = 3'b100
    } mon_state_t;
endpackage

// *** hw/sha_engine.sv ***
// SHA1 / SHA224 / SHA256 block engine, one round per clock
`timescale 1ns/1ps
module sha_engine (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Control
    input wire logic i_init,
    input wire logic [1:0] i_algo,
    input wire logic i_go,
    input wire logic [511:0] i_block,
    // Result
    output logic o_done,
    output logic [255:0] o_digest
);
    import mim_pkg::*;

    typedef struct packed {
        logic busy;
        logic [6:0] rnd;
        logic [1:0] algo;
        logic [7:0][31:0] h;
        logic [7:0][31:0] v;
        logic [15:0][31:0] w;
        logic done;
        logic [7:0][31:0] dig;
    } sha_t;

    sha_t r;
    sha_t n;

    function automatic logic [31:0] rotr(input logic [31:0] x, input int s);
        return (x >> s) | (x << (32 - s));
    endfunction

    always_comb begin
        logic [31:0] t1;
        logic [31:0] t2;
        logic [31:0] fv;
        logic [31:0] kk;
        logic [31:0] wn;
        logic last;
        t1 = '0;
        t2 = '0;
        fv = '0;
        kk = '0;
        wn = '0;
        last = 1'b0;
        n = r;
        n.done = 1'b0;
        if (i_init) begin
            n.algo = i_algo;
            n.h = (i_algo == ALGO_SHA1) ? IV_SHA1 :
                  (i_algo == ALGO_SHA224) ? IV_SHA224 : IV_SHA256;
        end else if (i_go && !r.busy) begin
            n.v = r.h;
            n.w = i_block;
            n.rnd = '0;
            n.busy = 1'b1;
        end else if (r.busy) begin
            if (r.algo == ALGO_SHA1) begin
                if (r.rnd < SHA1_P1) begin
                    fv = (r.v[6] & r.v[5]) | (~r.v[6] & r.v[4]);
                    kk = K_SHA1[0];
                end else if (r.rnd < SHA1_P2) begin
                    fv = r.v[6] ^ r.v[5] ^ r.v[4];
                    kk = K_SHA1[1];
                end else if (r.rnd < SHA1_P3) begin
                    fv = (r.v[6] & r.v[5]) | (r.v[6] & r.v[4]) |
                         (r.v[5] & r.v[4]);
                    kk = K_SHA1[2];
                end else begin
                    fv = r.v[6] ^ r.v[5] ^ r.v[4];
                    kk = K_SHA1[3];
                end
                t1 = rotr(r.v[7], 27) + fv + r.v[3] + kk + r.w[15];
                wn = rotr(r.w[2] ^ r.w[7] ^ r.w[13] ^ r.w[15], 31);
                n.v[7:3] = {t1, r.v[7], rotr(r.v[6], 2), r.v[5], r.v[4]};
                last = (r.rnd == ROUNDS_SHA1 - 7'h1);
            end else begin
                t1 = r.v[0] + (rotr(r.v[3], 6) ^ rotr(r.v[3], 11) ^
                     rotr(r.v[3], 25)) + ((r.v[3] & r.v[2]) ^
                     (~r.v[3] & r.v[1])) + K_SHA2[r.rnd[5:0]] + r.w[15];
                t2 = (rotr(r.v[7], 2) ^ rotr(r.v[7], 13) ^ rotr(r.v[7], 22))
                     + ((r.v[7] & r.v[6]) ^ (r.v[7] & r.v[5]) ^
                     (r.v[6] & r.v[5]));
                wn = (rotr(r.w[1], 17) ^ rotr(r.w[1], 19) ^ (r.w[1] >> 10))
                     + r.w[6] + (rotr(r.w[14], 7) ^ rotr(r.w[14], 18) ^
                     (r.w[14] >> 3)) + r.w[15];
                n.v = {t1 + t2, r.v[7:5], r.v[4] + t1, r.v[3:1]};
                last = (r.rnd == ROUNDS_SHA2 - 7'h1);
            end
            n.w = {r.w[14:0], wn};
            n.rnd = r.rnd + 7'h1;
            if (last) begin
                n.busy = 1'b0;
                n.done = 1'b1;
                for (int i = 0; i < 8; i++) begin
                    n.h[i] = r.h[i] + n.v[i];
                end
                // Unused words stay zero so compare ignores them
                n.dig = n.h;
                if (r.algo == ALGO_SHA224) begin
                    n.dig[0] = '0;
                end
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign o_done = r.done;
    assign o_digest = r.dig;

    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    a_sha2_rounds: assert property (
        i_go && !i_init && !r.busy && r.algo != ALGO_SHA1 |-> ##65 o_done)
        else $error("SHA2 block did not finish in 64 rounds");
    a_sha1_rounds: assert property (
        i_go && !i_init && !r.busy && r.algo == ALGO_SHA1 |-> ##81 o_done)
        else $error("SHA1 block did not finish in 80 rounds");
    a_digest_width: assert property (
        o_done |-> (r.algo == ALGO_SHA1 ? o_digest[95:0] == '0 :
        r.algo == ALGO_SHA224 ? o_digest[31:0] == '0 : 1'b1))
        else $error("Digest wider than the selected algorithm");
endmodule

// *** hw/memory_integrity_monitor.sv ***
// Memory integrity monitor: descriptor walker, DMA master, registers
`timescale 1ns/1ps
module memory_integrity_monitor (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Register port
    input wire logic [mim_pkg::ADDR_W-1:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [31:0] o_reg_rdata,
    // Memory master
    output logic o_mem_req,
    output logic o_mem_we,
    output logic [31:0] o_mem_addr,
    output logic [31:0] o_mem_wdata,
    input wire logic i_mem_ack,
    input wire logic [31:0] i_mem_rdata,
    // Interrupt
    output logic o_irq
);
    import mim_pkg::*;

    typedef struct packed {
        mon_state_t st;
        logic [1:0] idx;
        logic [3:0] cnt;
        logic [CNT_W:0] left;
        logic [3:0][31:0] desc;
        logic [15:0][31:0] blk;
        logic [31:0] baddr;
        logic miss;
        logic init;
        logic go;
        logic req;
        logic we;
        logic [31:0] maddr;
        logic [31:0] wdata;
        logic en;
        logic [31:0] base;
        logic [EV_W-1:0] status;
        logic [EV_W-1:0] mask;
        logic [31:0] rdata;
        logic irq;
    } mon_t;

    mon_t r;
    mon_t n;
    logic hash_done;
    logic [255:0] digest;
    logic [1:0] algo;
    logic cmp_mode;
    logic wrap;
    logic end_of_monitoring_bit;
    logic dig_ack;
    logic dig_fin;
    logic miss_now;
    logic [1:0] next_idx;

    function automatic logic [31:0] desc_addr(input logic [31:0] base,
            input logic [1:0] idx, input logic [3:0] cnt);
        return base + {26'h0, idx, 4'h0} + {26'h0, cnt, 2'h0};
    endfunction

    function automatic logic [31:0] dig_word(input logic [7:0][31:0] d,
            input logic [3:0] i);
        return d[WORD_TOP - i[2:0]];
    endfunction

    function automatic logic [3:0] dig_words(input logic [1:0] a);
        return (a == ALGO_SHA1) ? DIGW_SHA1 :
               (a == ALGO_SHA224) ? DIGW_SHA224 : DIGW_SHA256;
    endfunction

    sha_engine u_sha_engine (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_init(r.init),
        .i_algo(algo),
        .i_go(r.go),
        .i_block(r.blk),
        .o_done(hash_done),
        .o_digest(digest)
    );

    assign algo = r.desc[DW_CFG][CFG_ALGO_LSB +: 2];
    assign cmp_mode = r.desc[DW_CFG][CFG_CMP_BIT];
    assign wrap = r.desc[DW_CFG][CFG_WRAP_BIT];
    assign end_of_monitoring_bit = r.desc[DW_CFG][CFG_EOM_BIT];
    assign dig_ack = (r.st == S_DIG) && i_mem_ack;
    assign dig_fin = dig_ack && (r.cnt == dig_words(algo) - 4'h1);
    assign miss_now = r.miss || (dig_ack && cmp_mode &&
                      i_mem_rdata != dig_word(digest, r.cnt));
    // Past the fourth region the list always closes on itself
    assign next_idx = (wrap || r.idx == REGION_LAST) ? 2'h0 :
                      r.idx + 2'h1;

    always_comb begin
        logic [EV_W-1:0] ev;
        logic [EV_W-1:0] clr;
        ev = '0;
        clr = '0;
        n = r;
        n.init = 1'b0;
        n.go = 1'b0;
        if (i_reg_wr) begin
            case (i_reg_addr)
                REG_CTRL: begin
                    n.en = i_reg_wdata[CTRL_EN_BIT];
                end
                REG_BASE: begin
                    n.base = i_reg_wdata;
                end
                REG_STATUS: begin
                    clr = i_reg_wdata[EV_W-1:0];
                end
                REG_MASK: begin
                    n.mask = i_reg_wdata[EV_W-1:0];
                end
                default: begin
                end
            endcase
        end
        case (r.st)
            S_IDLE: begin
                if (r.en) begin
                    n.idx = 2'h0;
                    n.cnt = 4'h0;
                    n.req = 1'b1;
                    n.we = 1'b0;
                    n.maddr = desc_addr(r.base, 2'h0, 4'h0);
                    n.st = S_DESC;
                end
            end
            S_DESC: begin
                if (i_mem_ack) begin
                    n.desc[r.cnt[1:0]] = i_mem_rdata;
                    if (r.cnt == DESC_LAST) begin
                        // Context loaded: engine reset and first block
                        n.init = 1'b1;
                        n.left = {1'b0, r.desc[DW_CTRL][CNT_W-1:0]} +
                                 {{CNT_W{1'b0}}, 1'b1};
                        n.baddr = r.desc[DW_START];
                        n.maddr = r.desc[DW_START];
                        n.cnt = 4'h0;
                        n.st = S_BLK;
                    end else begin
                        n.cnt = r.cnt + 4'h1;
                        n.maddr = desc_addr(r.base, r.idx,
                                            r.cnt + 4'h1);
                    end
                end
            end
            S_BLK: begin
                if (i_mem_ack) begin
                    n.blk[BLK_LAST - r.cnt] = i_mem_rdata;
                    if (r.cnt == BLK_LAST) begin
                        n.go = 1'b1;
                        n.req = 1'b0;
                        n.baddr = r.baddr + BLK_BYTES;
                        n.left = r.left - {{CNT_W{1'b0}}, 1'b1};
                        n.st = S_HASH;
                    end else begin
                        n.cnt = r.cnt + 4'h1;
                        n.maddr = r.maddr + WORD_BYTES;
                    end
                end
            end
            S_HASH: begin
                if (hash_done) begin
                    n.cnt = 4'h0;
                    n.miss = 1'b0;
                    n.req = 1'b1;
                    if (r.left != '0) begin
                        n.we = 1'b0;
                        n.maddr = r.baddr;
                        n.st = S_BLK;
                    end else begin
                        n.we = !cmp_mode;
                        n.maddr = r.desc[DW_DIG];
                        n.wdata = dig_word(digest, 4'h0);
                        n.st = S_DIG;
                    end
                end
            end
            S_DIG: begin
                if (dig_ack) begin
                    n.miss = miss_now;
                    if (dig_fin) begin
                        ev[EV_MISMATCH] = miss_now;
                        n.we = 1'b0;
                        n.cnt = 4'h0;
                        // Disable also lets the current region finish
                        if (end_of_monitoring_bit || !r.en) begin
                            // Drop enable, else idle relaunches the list
                            n.en = 1'b0;
                            n.req = 1'b0;
                            ev[EV_END] = 1'b1;
                            n.st = S_IDLE;
                        end else begin
                            n.idx = next_idx;
                            n.maddr = desc_addr(r.base, next_idx, 4'h0);
                            n.st = S_DESC;
                        end
                    end else begin
                        n.cnt = r.cnt + 4'h1;
                        n.maddr = r.maddr + WORD_BYTES;
                        n.wdata = dig_word(digest, r.cnt + 4'h1);
                    end
                end
            end
            default: begin
                n.req = 1'b0;
                n.st = S_IDLE;
            end
        endcase
        // A new event beats a same-cycle clear
        n.status = (r.status & ~clr) | ev;
        n.irq = |(n.status & n.mask);
        n.rdata = '0;
        if (i_reg_rd) begin
            case (i_reg_addr)
                REG_CTRL: n.rdata = {31'h0, r.en};
                REG_BASE: n.rdata = r.base;
                REG_STATUS: n.rdata = {30'h0, r.status};
                REG_MASK: n.rdata = {30'h0, r.mask};
                REG_STATE: n.rdata = {27'h0, r.idx, r.st};
                default: n.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign o_reg_rdata = r.rdata;
    assign o_mem_req = r.req;
    assign o_mem_we = r.we;
    assign o_mem_addr = r.maddr;
    assign o_mem_wdata = r.wdata;
    assign o_irq = r.irq;

    // Blocks handed to the engine since the last context load
    logic [CNT_W:0] seen_reg;
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            seen_reg <= '0;
        end else if (r.init) begin
            seen_reg <= '0;
        end else if (r.go) begin
            seen_reg <= seen_reg + {{CNT_W{1'b0}}, 1'b1};
        end
    end

    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    a_desc_addr: assert property (
        r.req && r.st == S_DESC |->
        r.maddr == desc_addr(r.base, r.idx, r.cnt))
        else $error("Descriptor word fetched from wrong address");
    a_hash_start: assert property (
        r.st == S_DESC && i_mem_ack && r.cnt == DESC_LAST |=>
        r.init && r.st == S_BLK && r.req && r.maddr == r.desc[DW_START])
        else $error("Hashing did not start after descriptor load");
    a_block_count: assert property (
        r.st == S_HASH && hash_done && r.left == '0 |->
        seen_reg == {1'b0, r.desc[DW_CTRL][CNT_W-1:0]} +
        {{CNT_W{1'b0}}, 1'b1})
        else $error("Wrong number of blocks hashed");
    a_result_path: assert property (
        r.st == S_HASH && hash_done && r.left == '0 |=>
        r.st == S_DIG && o_mem_req && o_mem_we == !cmp_mode)
        else $error("Digest not written back or compared");
    a_wb_data: assert property (
        r.st == S_DIG && o_mem_we |->
        o_mem_wdata == dig_word(digest, r.cnt))
        else $error("Written digest word differs from engine");
    a_mismatch_irq: assert property (
        dig_fin && miss_now |=>
        r.status[EV_MISMATCH] && (o_irq || !r.mask[EV_MISMATCH]))
        else $error("Mismatch did not raise its status bit");
    a_irq_gate: assert property (
        o_irq |-> $past(|(n.status & n.mask)))
        else $error("Interrupt high with no unmasked event");
    a_circular: assert property (
        dig_fin && r.en && !end_of_monitoring_bit && !wrap && r.idx != REGION_LAST |=>
        r.st == S_DESC && r.idx == $past(r.idx) + 2'h1)
        else $error("Did not step to the next descriptor");
    a_wrap_back: assert property (
        dig_fin && r.en && !end_of_monitoring_bit && (wrap || r.idx == REGION_LAST) |=>
        r.st == S_DESC && r.idx == 2'h0 && r.maddr == r.base)
        else $error("List did not return to the first descriptor");
    a_eom_stop: assert property (
        dig_fin && end_of_monitoring_bit |=> (r.st == S_IDLE && !o_mem_req)[*2])
        else $error("Fetching went on past the end marker");

    c_mismatch: cover property (dig_fin && miss_now && cmp_mode);
    c_wrap: cover property (dig_fin && r.en && wrap && !end_of_monitoring_bit);
    c_eom: cover property (dig_fin && end_of_monitoring_bit);
    c_sha1_region: cover property (dig_fin && algo == ALGO_SHA1);
endmodule

// *** tb/sysmem.sv ***
// Behavioural system memory answering the monitor's bus requests
`timescale 1ns/1ps
module sysmem (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Request side
    input wire logic i_req,
    input wire logic i_we,
    input wire logic [31:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic [2:0] i_dly,
    // Answer side
    output logic o_ack,
    output logic [31:0] o_rdata
);
    logic [31:0] mem [256];
    logic [2:0] cnt;
    // Idle data toggles so a stale word never looks valid
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_ack <= 1'b0;
            cnt <= 3'h0;
            o_rdata <= 32'h0;
        end else if (o_ack) begin
            o_ack <= 1'b0;
            o_rdata <= ~o_rdata;
        end else if (i_req && cnt >= i_dly) begin
            o_ack <= 1'b1;
            cnt <= 3'h0;
            if (i_we) mem[i_addr[9:2]] <= i_wdata;
            else o_rdata <= mem[i_addr[9:2]];
        end else begin
            if (i_req) cnt <= cnt + 3'h1;
            o_rdata <= ~o_rdata;
        end
    end
endmodule

// *** tb/memory_integrity_monitor_tb.sv ***
// Testbench of the memory integrity monitor
`timescale 1ns/1ps
module memory_integrity_monitor_tb;
    import mim_pkg::*;
    typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} row_t;
    row_t rows [6] = '{'{REG_CTRL, 32'h0, 32'h0}, '{REG_BASE, 32'h40, 32'h40},
        '{REG_STATUS, 32'h3, 32'h0}, '{REG_MASK, 32'h3, 32'h3},
        '{REG_STATE, 32'h7, 32'h0}, '{8'h14, 32'hFF, 32'h0}};
    // Digests of the padded three-byte message: 160, 224, 256 bits
    logic [31:0] dg [20] = '{32'hA9993E36, 32'h4706816A, 32'hBA3E2571,
        32'h7850C26C, 32'h9CD0D89D, 32'h23097D22, 32'h3405D822, 32'h8642A477,
        32'hBDA255B3, 32'h2AADBCE4, 32'hBDA0B3F7, 32'hE36C9DA7, 32'hBA7816BF,
        32'h8F01CFEA, 32'h414140DE, 32'h5DAE2223, 32'hB00361A3, 32'h96177A9C,
        32'hB410FF61, 32'hF20015AD};
    logic i_core_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [7:0] addr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata, maddr, mwdata, mrdata, d;
    logic req, we, ack, irq;
    logic [2:0] dly = 3'h0;
    int failures = 0;
    int n_checks = 0;
    int nblk, nd0, nd1, k;
    always #10 i_core_clk = ~i_core_clk;
    memory_integrity_monitor u_memory_integrity_monitor (.i_core_clk,
        .i_rst_n, .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr),
        .i_reg_rd(rd), .o_reg_rdata(rdata), .o_mem_req(req), .o_mem_we(we),
        .o_mem_addr(maddr), .o_mem_wdata(mwdata), .i_mem_ack(ack),
        .i_mem_rdata(mrdata), .o_irq(irq));
    sysmem u_sysmem (.i_clk(i_core_clk), .i_rst_n, .i_req(req), .i_we(we),
        .i_addr(maddr), .i_wdata(mwdata), .i_dly(dly), .o_ack(ack),
        .o_rdata(mrdata));
    always @(posedge i_core_clk) begin
        if (req && ack && !we) begin
            if (maddr[31:8] == 24'h1) nblk++;
            if (maddr == 32'h0) nd0++;
            if (maddr == 32'h10) nd1++;
        end
    end
    task automatic chk(string n, logic [31:0] g, logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic reg_wr(logic [7:0] a, logic [31:0] v);
        @(posedge i_core_clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge i_core_clk);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(logic [7:0] a);
        @(posedge i_core_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge i_core_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic wait_end();
        k = 0;
        d = 32'h0;
        while (d[1] !== 1'b1 && k < 2000) begin
            reg_rd(REG_STATUS);
            k++;
        end
    endtask
    task automatic desc(int i, logic [31:0] s, c, n, g);
        u_sysmem.mem[i*4] = s;
        u_sysmem.mem[i*4+1] = c;
        u_sysmem.mem[i*4+2] = n;
        u_sysmem.mem[i*4+3] = g;
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge i_core_clk);
        failures++;
        wrap_up();
    end
    initial begin
        // Caller supplies an already padded block
        // Second block of the two-block region is all zeros
        for (int i = 0; i < 32; i++) u_sysmem.mem[64+i] = 32'h0;
        u_sysmem.mem[64] = 32'h61626380;
        u_sysmem.mem[79] = 32'h00000018;
        repeat (3) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        #1 chk("req", {31'h0, req}, 32'h0);
        foreach (rows[i]) begin
            reg_rd(rows[i].a);
            chk("rst", d, 32'h0);
            reg_wr(rows[i].a, rows[i].w);
            reg_rd(rows[i].a);
            chk("rw", d, rows[i].e);
        end
        $display("registers done");
        desc(0, 32'h100, 32'h00, 32'h0, 32'h200);
        desc(1, 32'h100, 32'h20, 32'h0, 32'h240);
        desc(2, 32'h100, 32'h16, 32'h0, 32'h280);
        for (int i = 0; i < 8; i++) u_sysmem.mem[160+i] = dg[12+i];
        reg_wr(REG_BASE, 32'h0);
        reg_wr(REG_CTRL, 32'h1);
        wait_end();
        chk("status", d, 32'h2);
        chk("irq", {31'h0, irq}, 32'h1);
        for (int i = 0; i < 5; i++) begin
            chk("sha1", u_sysmem.mem[128+i], dg[i]);
        end
        for (int i = 0; i < 7; i++) begin
            chk("sha224", u_sysmem.mem[144+i], dg[5+i]);
        end
        // Walker must stay idle after the end marker
        reg_rd(REG_STATE);
        chk("stop", {29'h0, d[2:0]}, 32'h0);
        reg_wr(REG_STATUS, 32'h3);
        reg_rd(REG_STATUS);
        chk("w1c", d, 32'h0);
        chk("irq", {31'h0, irq}, 32'h0);
        $display("write back done");
        // Two blocks, compare against a reference that cannot match
        desc(0, 32'h100, 32'h16, 32'h1, 32'h280);
        nblk = 0;
        reg_wr(REG_MASK, 32'h1);
        reg_wr(REG_CTRL, 32'h0);
        reg_wr(REG_CTRL, 32'h1);
        wait_end();
        chk("status", d, 32'h3);
        chk("blocks", nblk, 32);
        chk("irq", {31'h0, irq}, 32'h1);
        reg_wr(REG_MASK, 32'h0);
        reg_rd(REG_STATUS);
        chk("irq", {31'h0, irq}, 32'h0);
        reg_wr(REG_STATUS, 32'h3);
        $display("compare done");
        // Wrap set, end clear: continuous loop over one region
        desc(0, 32'h100, 32'h11, 32'h0, 32'h2C0);
        dly = 3'h3;
        nd0 = 0;
        nd1 = 0;
        reg_wr(REG_CTRL, 32'h0);
        reg_wr(REG_CTRL, 32'h1);
        for (int i = 0; i < 5000 && nd0 < 3; i++) @(posedge i_core_clk);
        reg_wr(REG_CTRL, 32'h0);
        wait_end();
        chk("wrap", nd1, 0);
        chk("loops", nd0 >= 3, 1);
        for (int i = 0; i < 8; i++) begin
            chk("sha256", u_sysmem.mem[176+i], dg[12+i]);
        end
        $display("wrap done");
        wrap_up();
    end
endmodule
